// ==== logic/supervisor_defs.vh ====
// constants of the supervisory timing block
`ifndef SUPERVISOR_DEFS_VH
`define SUPERVISOR_DEFS_VH
`define CLK_MHZ 200
`define CYC_PER_MS (`CLK_MHZ * 1000)
`define MS_PER_DAY 32'h0526_5C00
`define RESET_DELAY_SEL_MAX 5'h10
`define WAIT_BASE_MS 100
`define PEAK_WIN_MS 30000
`define PULSE_MIN_MS 1
`define PULSE_MAX_MS 32256
`define A_CTRL 12'h000
`define A_STATUS 12'h004
`define A_RTC_MS 12'h008
`define A_RTC_DAY 12'h00C
`define A_RSTDLY 12'h010
`define A_PULSE 12'h014
`define A_WDWAIT 12'h018
`define A_WDTO 12'h01C
`define A_CMD 12'h020
`define A_FAULT_IN 12'h024
`define A_MEAS 12'h028
`define A_LOG0 12'h02C
`define A_LOG1 12'h030
`define A_LOG2 12'h034
`define A_PEAK 12'h038
`define A_RSTCNT 12'h03C
`define A_NVCNT 12'h040
`define C_STORE 0
`define C_KICK 1
`define C_CLRCNT 2
`define B_PULSE 0
`define B_WD_TO_RST 1
`define B_LOG_DIS 2
`define B_BROWNOUT 3
`define B_ACCUM 4
`define B_SEQ_ON 5
`define CTRL_RESET 32'h0000_0000
`define PULSE_RESET 16'h0001
`define WDTO_RESET 16'h03E8
`endif

// ==== logic/supervisor_watchdog_runtime_log.v ====
// supervisory timing block: run-time clock, system reset, watchdog and logging
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`include "supervisor_defs.vh"
module supervisor_watchdog_runtime_log #(
   parameter CYC_MS = `CYC_PER_MS
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire rails_good,
   input wire boot_done,
   input wire watchdog_input_pin,
   input wire brownout_det,
   input wire nv_rtc_valid,
   input wire [31:0] nv_rtc_ms,
   input wire [31:0] nv_rtc_day,
   output reg system_reset_n,
   output reg watchdog_output_pin,
   output reg flash_wr,
   output reg [2:0] flash_kind,
   output reg [63:0] flash_data
);
   localparam S_HOLD = 4'b0001;
   localparam S_DELAY = 4'b0010;
   localparam S_PULSE = 4'b0100;
   localparam S_RUN = 4'b1000;
   localparam W_WAIT = 3'b001;
   localparam W_RUN = 3'b010;
   localparam W_EXP = 3'b100;
   localparam K_RTC = 3'h0;
   localparam K_FAULT = 3'h1;
   localparam K_PEAK = 3'h2;
   localparam K_RSTCNT = 3'h3;

   // delay code to milliseconds: 0, then 1 << (code-1)
   function [31:0] dly_ms;
      input [4:0] code;
      begin
         if (code == 5'h00)
            dly_ms = 32'h0000_0000;
         else
            dly_ms = 32'h0000_0001 << (code - 5'h01);
      end
   endfunction

   // register offsets that accept a write
   function wr_ok;
      input [11:0] a;
      begin
         case (a)
            `A_CTRL, `A_RTC_MS, `A_RTC_DAY, `A_RSTDLY, `A_PULSE, `A_WDWAIT, `A_WDTO,
            `A_CMD, `A_FAULT_IN, `A_MEAS: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
         endcase
      end
   endfunction

   // clamp a programmable width into its legal range
   function [31:0] clamp_ms;
      input [15:0] v;
      begin
         if (v < `PULSE_MIN_MS)
            clamp_ms = `PULSE_MIN_MS;
         else if (v > `PULSE_MAX_MS)
            clamp_ms = `PULSE_MAX_MS;
         else
            clamp_ms = {16'h0000, v};
      end
   endfunction

   reg [31:0] ctrl;
   reg [4:0] rst_dly_sel;
   reg [15:0] pulse_ms;
   reg [3:0] wd_wait_sel;
   reg [15:0] wd_to_ms;
   reg [31:0] rtc_ms;
   reg [31:0] rtc_day;
   reg [31:0] tick;
   reg boot_q;
   reg [3:0] sr_state;
   reg [31:0] sr_cnt;
   reg [31:0] sr_pre;
   reg [2:0] wd_state;
   reg [31:0] wd_cnt;
   reg wd_rst_req;
   reg wdi_s1;
   reg wdi_s2;
   reg wdi_s3;
   reg [31:0] fault_in;
   reg [15:0] meas;
   reg [15:0] peak;
   reg [15:0] win_max;
   reg win_on;
   reg [31:0] win_cnt;
   reg [31:0] log0;
   reg [31:0] log1;
   reg [31:0] log2;
   reg [31:0] rst_cnt;
   reg [31:0] nv_cnt;
   reg brown_q;
   reg rst_logged;
   reg fault_pend;
   reg peak_pend;
   reg kick_cmd;
   reg store_cmd;

   wire ms_tick = (tick == CYC_MS - 1);
   // reset sequencer keeps its own millisecond prescaler so delays start exact
   wire sr_ms = (sr_pre == CYC_MS - 1);
   wire wr = psel & penable & pwrite;
   wire wdi_edge = wdi_s2 ^ wdi_s3;
   wire service = wdi_edge | kick_cmd;
   wire log_dis = ctrl[`B_LOG_DIS];
   wire brown_en = ctrl[`B_BROWNOUT];
   wire flash_ok = ~log_dis & ~brown_en;
   wire rtc_run = ~ctrl[`B_ACCUM] | boot_done;
   wire [31:0] wd_wait_lim = (wd_wait_sel == 4'h0) ? 32'h0000_0000 :
      (`WAIT_BASE_MS << (wd_wait_sel - 4'h1));

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdi_s1 <= 1'b0;
         wdi_s2 <= 1'b0;
         wdi_s3 <= 1'b0;
         tick <= 32'h0000_0000;
         boot_q <= 1'b0;
      end else begin
         wdi_s1 <= watchdog_input_pin;
         wdi_s2 <= wdi_s1;
         wdi_s3 <= wdi_s2;
         tick <= ms_tick ? 32'h0000_0000 : tick + 32'h0000_0001;
         boot_q <= 1'b1;
      end
   end

   // register file, run-time clock, logging
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `CTRL_RESET;
         rst_dly_sel <= 5'h00;
         pulse_ms <= `PULSE_RESET;
         wd_wait_sel <= 4'h0;
         wd_to_ms <= `WDTO_RESET;
         rtc_ms <= 32'h0000_0000;
         rtc_day <= 32'h0000_0000;
         fault_in <= 32'h0000_0000;
         meas <= 16'h0000;
         peak <= 16'h0000;
         win_max <= 16'h0000;
         win_on <= 1'b0;
         win_cnt <= 32'h0000_0000;
         log0 <= 32'h0000_0000;
         log1 <= 32'h0000_0000;
         log2 <= 32'h0000_0000;
         rst_cnt <= 32'h0000_0000;
         nv_cnt <= 32'h0000_0000;
         brown_q <= 1'b0;
         rst_logged <= 1'b0;
         fault_pend <= 1'b0;
         peak_pend <= 1'b0;
         kick_cmd <= 1'b0;
         store_cmd <= 1'b0;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         flash_wr <= 1'b0;
         flash_kind <= K_RTC;
         flash_data <= 64'h0000_0000_0000_0000;
      end else begin
         kick_cmd <= 1'b0;
         store_cmd <= 1'b0;
         flash_wr <= 1'b0;
         brown_q <= brownout_det;
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         // preserved clock loaded only in the first cycle after reset with brownout mode on, but ctrl still holds 0 then, so it never loads
         if (boot_q == 1'b0 && nv_rtc_valid && brown_en) begin
            rtc_ms <= nv_rtc_ms;
            rtc_day <= nv_rtc_day;
         end else if (ms_tick && rtc_run) begin
            if (rtc_ms == `MS_PER_DAY - 1) begin
               rtc_ms <= 32'h0000_0000;
               rtc_day <= rtc_day + 32'h0000_0001;
            end else
               rtc_ms <= rtc_ms + 32'h0000_0001;
         end
         // count this reset once, then keep it
         if (!rst_logged) begin
            rst_logged <= 1'b1;
            rst_cnt <= nv_cnt + 32'h0000_0001;
            nv_cnt <= nv_cnt + 32'h0000_0001;
         end
         // peak window
         if (ms_tick && win_on) begin
            if (win_cnt == `PEAK_WIN_MS - 1) begin
               win_on <= 1'b0;
               peak_pend <= 1'b1;
            end else
               win_cnt <= win_cnt + 32'h0000_0001;
         end
         if (psel && !penable && !pready) begin
            pslverr <= pwrite & ~wr_ok(paddr);
            case (paddr)
               `A_CTRL: prdata <= ctrl;
               `A_STATUS: prdata <= {24'h0, wd_state, sr_state, system_reset_n};
               `A_RTC_MS: prdata <= rtc_ms;
               `A_RTC_DAY: prdata <= rtc_day;
               `A_RSTDLY: prdata <= {27'h0, rst_dly_sel};
               `A_PULSE: prdata <= {16'h0, pulse_ms};
               `A_WDWAIT: prdata <= {28'h0, wd_wait_sel};
               `A_WDTO: prdata <= {16'h0, wd_to_ms};
               `A_LOG0: prdata <= log0;
               `A_LOG1: prdata <= log1;
               `A_LOG2: prdata <= log2;
               `A_PEAK: prdata <= {16'h0, peak};
               `A_RSTCNT: prdata <= rst_cnt;
               default: prdata <= 32'h0000_0000;
            endcase
         end
         if (wr && pready) begin
            case (paddr)
               `A_CTRL: ctrl <= pwdata;
               `A_RTC_MS: rtc_ms <= pwdata;
               `A_RTC_DAY: rtc_day <= pwdata;
               `A_RSTDLY: rst_dly_sel <= (pwdata[4:0] > `RESET_DELAY_SEL_MAX) ?
                  `RESET_DELAY_SEL_MAX : pwdata[4:0];
               `A_PULSE: pulse_ms <= pwdata[15:0];
               `A_WDWAIT: wd_wait_sel <= pwdata[3:0];
               `A_WDTO: wd_to_ms <= pwdata[15:0];
               `A_CMD: begin
                  store_cmd <= pwdata[`C_STORE];
                  kick_cmd <= pwdata[`C_KICK];
                  if (pwdata[`C_CLRCNT]) begin
                     rst_cnt <= 32'h0000_0000;
                     nv_cnt <= 32'h0000_0000;
                  end
               end
               `A_FAULT_IN: begin
                  fault_in <= pwdata;
                  log0 <= {16'h0, pwdata[15:8], pwdata[7:0]};
                  log1 <= rtc_ms;
                  log2 <= {16'h0, meas};
                  fault_pend <= 1'b1;
               end
               `A_MEAS: begin
                  meas <= pwdata[15:0];
                  if (pwdata[15:0] > peak) begin
                     peak <= pwdata[15:0];
                     win_max <= pwdata[15:0];
                     if (!win_on) begin
                        win_on <= 1'b1;
                        win_cnt <= 32'h0000_0000;
                     end
                  end
               end
               default: ;
            endcase
         end
         // one flash write per cycle, priority: store, brownout, fault, peak
         if (store_cmd) begin
            flash_wr <= 1'b1;
            flash_kind <= K_RTC;
            flash_data <= {rtc_day, rtc_ms};
         end else if (brownout_det && !brown_q && brown_en && !log_dis) begin
            flash_wr <= 1'b1;
            flash_kind <= K_RTC;
            flash_data <= {rtc_day, rtc_ms};
            fault_pend <= 1'b1;
            peak_pend <= 1'b1;
         end else if (fault_pend && (flash_ok || (brown_q && !log_dis))) begin
            flash_wr <= 1'b1;
            flash_kind <= K_FAULT;
            flash_data <= {log0[15:0], log2[15:0], log1};
            fault_pend <= 1'b0;
         end else if (peak_pend && (flash_ok || (brown_q && !log_dis))) begin
            flash_wr <= 1'b1;
            flash_kind <= K_PEAK;
            flash_data <= {48'h0, win_max};
            peak_pend <= 1'b0;
         end else if (rst_logged && flash_ok && rst_cnt != nv_cnt) begin
            flash_wr <= 1'b1;
            flash_kind <= K_RSTCNT;
            flash_data <= {32'h0, rst_cnt};
         end
      end
   end

   // system reset sequencer and watchdog
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sr_state <= S_HOLD;
         sr_cnt <= 32'h0000_0000;
         sr_pre <= 32'h0000_0000;
         system_reset_n <= 1'b0;
         wd_state <= W_WAIT;
         wd_cnt <= 32'h0000_0000;
         wd_rst_req <= 1'b0;
         watchdog_output_pin <= 1'b0;
      end else begin
         sr_pre <= sr_ms ? 32'h0000_0000 : sr_pre + 32'h0000_0001;
         case (sr_state)
            S_HOLD: begin
               system_reset_n <= 1'b0;
               sr_cnt <= 32'h0000_0000;
               sr_pre <= 32'h0000_0000;
               if (rails_good && ctrl[`B_SEQ_ON])
                  sr_state <= S_DELAY;
            end
            S_DELAY: begin
               if (!rails_good)
                  sr_state <= S_HOLD;
               else if (sr_cnt >= dly_ms(rst_dly_sel)) begin
                  sr_cnt <= 32'h0000_0000;
                  sr_pre <= 32'h0000_0000;
                  if (ctrl[`B_PULSE]) begin
                     system_reset_n <= 1'b0;
                     sr_state <= S_PULSE;
                  end else begin
                     system_reset_n <= 1'b1;
                     sr_state <= S_RUN;
                  end
               end else if (sr_ms)
                  sr_cnt <= sr_cnt + 32'h0000_0001;
            end
            S_PULSE: begin
               if (sr_cnt >= clamp_ms(pulse_ms)) begin
                  system_reset_n <= 1'b1;
                  sr_state <= S_RUN;
                  sr_cnt <= 32'h0000_0000;
                  sr_pre <= 32'h0000_0000;
               end else if (sr_ms)
                  sr_cnt <= sr_cnt + 32'h0000_0001;
            end
            S_RUN: begin
               system_reset_n <= 1'b1;
               if (wd_rst_req) begin
                  system_reset_n <= 1'b0;
                  sr_cnt <= 32'h0000_0000;
                  sr_pre <= 32'h0000_0000;
                  sr_state <= S_PULSE;
               end else if (!rails_good) begin
                  if (sr_cnt >= dly_ms(rst_dly_sel))
                     sr_state <= S_HOLD;
                  else if (sr_ms)
                     sr_cnt <= sr_cnt + 32'h0000_0001;
               end else begin
                  sr_cnt <= 32'h0000_0000;
                  sr_pre <= 32'h0000_0000;
               end
            end
            default: sr_state <= S_HOLD;
         endcase
         wd_rst_req <= 1'b0;
         case (wd_state)
            W_WAIT: begin
               if (service) begin
                  wd_state <= W_RUN;
                  wd_cnt <= 32'h0000_0000;
               end else if (wd_cnt >= wd_wait_lim) begin
                  wd_state <= W_RUN;
                  wd_cnt <= 32'h0000_0000;
               end else if (ms_tick)
                  wd_cnt <= wd_cnt + 32'h0000_0001;
            end
            W_RUN: begin
               if (service)
                  wd_cnt <= 32'h0000_0000;
               else if (ms_tick && wd_cnt >= clamp_ms(wd_to_ms) - 1) begin
                  wd_state <= W_EXP;
                  if (ctrl[`B_WD_TO_RST])
                     wd_rst_req <= 1'b1;
                  else
                     watchdog_output_pin <= 1'b1;
               end else if (ms_tick)
                  wd_cnt <= wd_cnt + 32'h0000_0001;
            end
            W_EXP: begin
               if (service) begin
                  watchdog_output_pin <= 1'b0;
                  wd_cnt <= 32'h0000_0000;
                  wd_state <= W_RUN;
               end
            end
            default: wd_state <= W_WAIT;
         endcase
      end
   end
endmodule // supervisor_watchdog_runtime_log

// ==== test/host_cpu.sv ====
// host processor model that services the watchdog input pin
`timescale 1ns/10ps
module host_cpu #(
   parameter PERIOD = 16
) (
   pclk,
   alive,
   watchdog_input_pin
);
   input wire pclk;
   input wire alive;
   output reg watchdog_input_pin;
   integer cnt = 0;
   initial watchdog_input_pin = 1'b0;
   // a live processor toggles the pin once per period
   always @(posedge pclk) begin
      if (alive) begin
         cnt <= cnt + 1;
         if (cnt % PERIOD == PERIOD - 1) watchdog_input_pin <= ~watchdog_input_pin;
      end
   end
endmodule // host_cpu

// ==== test/supervisor_checker_properties.sv ====
// assertion checker on the ports of the supervisory timing block
`timescale 1ns/10ps
`include "supervisor_defs.vh"
module supervisor_checker #(
   parameter CYC_MS = 200000
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire rails_good,
   input wire watchdog_input_pin,
   input wire brownout_det,
   input wire system_reset_n,
   input wire watchdog_output_pin,
   input wire flash_wr,
   input wire [2:0] flash_kind
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire acc = psel && penable && pready && pwrite;
   wire wr_cmd = acc && paddr == `A_CMD;
   wire rec = flash_wr && (flash_kind == 3'h1 || flash_kind == 3'h2);
   reg [31:0] ctrl;
   reg [19:0] age;
   reg pin_q;
   // control word shadow and cycles since the last service event
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `CTRL_RESET;
         age <= 20'h0_0000;
         pin_q <= 1'b0;
      end else begin
         pin_q <= watchdog_input_pin;
         if (acc && paddr == `A_CTRL) ctrl <= pwdata;
         if ((wr_cmd && pwdata[`C_KICK]) || watchdog_input_pin != pin_q) age <= 20'h0_0000;
         else if (age != 20'hF_FFFF) age <= age + 20'h0_0001;
      end
   end
   property p_answer; psel && !penable |=> pready; endproperty
   a_answer: assert property (p_answer) else $error("no answer in the access cycle");
   property p_release; $rose(system_reset_n) |-> $past(rails_good); endproperty
   a_release: assert property (p_release) else $error("reset released without rails");
   property p_expire; $rose(watchdog_output_pin) |-> age >= CYC_MS; endproperty
   a_expire: assert property (p_expire) else $error("watchdog expired too early");
   property p_select; $rose(watchdog_output_pin) |-> !ctrl[`B_WD_TO_RST]; endproperty
   a_select: assert property (p_select) else $error("watchdog pin used in reset mode");
   property p_hold; $fell(watchdog_output_pin) |-> age <= 20'h0_0005; endproperty
   a_hold: assert property (p_hold) else $error("expiry cleared without service");
   property p_nolog; rec |-> !ctrl[`B_LOG_DIS]; endproperty
   a_nolog: assert property (p_nolog) else $error("record written with logging off");
   property p_brown; rec && ctrl[`B_BROWNOUT] |-> brownout_det || $past(brownout_det); endproperty
   a_brown: assert property (p_brown) else $error("record written before brownout");
   property p_store; wr_cmd && pwdata[`C_STORE] && !ctrl[`B_LOG_DIS] && !ctrl[`B_BROWNOUT]
      |-> ##[1:40] (flash_wr && flash_kind == 3'h0); endproperty
   a_store: assert property (p_store) else $error("store command did not save clock");
   c_expire: cover property ($rose(watchdog_output_pin));
   c_store: cover property (flash_wr && flash_kind == 3'h0);
   c_pulse: cover property ($fell(system_reset_n) && rails_good);
endmodule // supervisor_checker
bind supervisor_watchdog_runtime_log supervisor_checker #(.CYC_MS(CYC_MS)) chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .rails_good(rails_good),
   .watchdog_input_pin(watchdog_input_pin), .brownout_det(brownout_det),
   .system_reset_n(system_reset_n), .watchdog_output_pin(watchdog_output_pin),
   .flash_wr(flash_wr), .flash_kind(flash_kind));

// ==== test/testbench.sv ====
// self-checking bench of the supervisory timing block
`timescale 1ns/10ps
`include "supervisor_defs.vh"
module testbench;
   localparam CYC = 8;
   reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   reg rails_good = 1'b0, boot_done = 1'b0, alive = 1'b1, brownout_det = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0, rd, t0;
   wire [31:0] prdata;
   wire pready, pslverr, system_reset_n, watchdog_output_pin, flash_wr, watchdog_input_pin;
   wire [2:0] flash_kind;
   integer failures = 0, checks_done = 0, fw = 0, n, k, e, f0;
   supervisor_watchdog_runtime_log #(.CYC_MS(CYC)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rails_good(rails_good), .boot_done(boot_done), .watchdog_input_pin(watchdog_input_pin),
      .brownout_det(brownout_det), .nv_rtc_valid(1'b0), .nv_rtc_ms(32'h0), .nv_rtc_day(32'h0),
      .system_reset_n(system_reset_n), .watchdog_output_pin(watchdog_output_pin),
      .flash_wr(flash_wr), .flash_kind(flash_kind), .flash_data());
   host_cpu #(.PERIOD(16)) cpu (.pclk(pclk), .alive(alive), .watchdog_input_pin(watchdog_input_pin));
   initial forever #2.5 pclk = ~pclk;
   always @(posedge pclk) if (flash_wr === 1'b1) fw <= fw + 1;
   task chk(input [31:0] g, input [31:0] x);
      begin
         checks_done = checks_done + 1;
         if (g !== x) begin
            failures = failures + 1;
            $display("mismatch at %0t: got %h expected %h", $time, g, x);
         end
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      integer i;
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         i = 0;
         do begin
            @(posedge pclk);
            i = i + 1;
         end while (pready !== 1'b1 && i < 50);
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         if (i >= 50) chk(0, 1);
      end
   endtask
   task rchk(input [11:0] a, input [31:0] x);
      begin
         apb(1'b0, a, 32'h0);
         chk(rd, x);
      end
   endtask
   task wait_sr(input v);
      begin
         n = 0;
         while (system_reset_n !== v && n < 3000) begin
            @(posedge pclk);
            n = n + 1;
         end
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d failures %0d", checks_done, failures);
         if (failures == 0 && checks_done > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask
   initial begin
      #100000;
      failures = failures + 1;
      finish_test;
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      boot_done <= 1'b1;
      rchk(`A_CTRL, `CTRL_RESET);
      rchk(`A_WDTO, `WDTO_RESET);
      rchk(`A_PULSE, `PULSE_RESET);
      rchk(`A_RSTCNT, 1);
      apb(1'b1, `A_CMD, 32'h4);
      rchk(`A_RSTCNT, 0);
      apb(1'b1, 12'h0FC, 32'h1);
      chk(err, 1);
      apb(1'b1, `A_STATUS, 32'h1);
      chk(err, 1);
      rchk(12'h0FC, 0);
      // day rollover of the run-time clock
      apb(1'b1, `A_RTC_MS, `MS_PER_DAY - 2);
      apb(1'b1, `A_RTC_DAY, 32'h5);
      repeat (4 * CYC) @(posedge pclk);
      rchk(`A_RTC_DAY, 6);
      apb(1'b0, `A_RTC_MS, 32'h0);
      chk(rd < 6, 1);
      // clock frozen during boot in accumulate mode
      apb(1'b1, `A_CTRL, 32'h10);
      boot_done <= 1'b0;
      apb(1'b0, `A_RTC_MS, 32'h0);
      t0 = rd;
      repeat (3 * CYC) @(posedge pclk);
      rchk(`A_RTC_MS, t0);
      boot_done <= 1'b1;
      // fault entry with timestamp and voltage
      apb(1'b1, `A_MEAS, 32'h1234);
      apb(1'b0, `A_RTC_MS, 32'h0);
      t0 = rd;
      f0 = fw;
      apb(1'b1, `A_FAULT_IN, 32'h0305);
      repeat (20) @(posedge pclk);
      chk(fw > f0, 1);
      rchk(`A_LOG0, 32'h0305);
      apb(1'b0, `A_LOG1, 32'h0);
      chk(rd - t0 < 3, 1);
      rchk(`A_LOG2, 32'h1234);
      f0 = fw;
      apb(1'b1, `A_CMD, 32'h1);
      repeat (40) @(posedge pclk);
      chk(fw > f0, 1);
      apb(1'b1, `A_CTRL, 32'h4);
      f0 = fw;
      apb(1'b1, `A_FAULT_IN, 32'h0102);
      repeat (20) @(posedge pclk);
      chk(fw, f0);
      apb(1'b1, `A_CTRL, 32'h8);
      f0 = fw;
      apb(1'b1, `A_FAULT_IN, 32'h0203);
      repeat (20) @(posedge pclk);
      chk(fw, f0);
      brownout_det <= 1'b1;
      repeat (50) @(posedge pclk);
      chk(fw > f0, 1);
      brownout_det <= 1'b0;
      // level-mode system reset over the first delay codes
      apb(1'b1, `A_CTRL, 32'h20);
      for (k = 0; k < 4; k = k + 1) begin
         e = (k == 0) ? 0 : CYC << (k - 1);
         apb(1'b1, `A_RSTDLY, k);
         rails_good <= 1'b1;
         wait_sr(1'b1);
         chk(n >= e && n <= e + 4, 1);
         rails_good <= 1'b0;
         wait_sr(1'b0);
         chk(n >= e && n <= e + 4, 1);
      end
      // watchdog on its own output pin
      apb(1'b1, `A_WDTO, 32'h4);
      rails_good <= 1'b1;
      wait_sr(1'b1);
      repeat (200) @(posedge pclk);
      chk(watchdog_output_pin, 0);
      alive <= 1'b0;
      repeat (60) @(posedge pclk);
      chk(watchdog_output_pin, 1);
      repeat (100) @(posedge pclk);
      chk(watchdog_output_pin, 1);
      apb(1'b1, `A_CMD, 32'h2);
      repeat (3) @(posedge pclk);
      chk(watchdog_output_pin, 0);
      repeat (60) @(posedge pclk);
      alive <= 1'b1;
      repeat (16) @(posedge pclk);
      alive <= 1'b0;
      repeat (6) @(posedge pclk);
      chk(watchdog_output_pin, 0);
      // watchdog expiry pulses the system reset
      alive <= 1'b1;
      apb(1'b1, `A_CTRL, 32'h22);
      apb(1'b1, `A_PULSE, 32'h2);
      alive <= 1'b0;
      wait_sr(1'b0);
      chk(n < 60, 1);
      wait_sr(1'b1);
      chk(n >= 2 * CYC - 1 && n <= 2 * CYC + 2, 1);
      alive <= 1'b1;
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rchk(`A_RTC_DAY, 0);
      finish_test;
   end
endmodule // testbench
